// >>> logic/essp_regs.vh
// Register offsets, fields, reset values and timing constants of the engine sequencer
// Assumes a 32-bit APB slave at 250 MHz; included by bare name
//
// Behaviour
// RULE1 - Cycle crank alternates adjustable crank and rest
// RULE2 - Oil pressure up raises governor to rated
// RULE3 - Normal stop waits cooldown, then cuts fuel
// RULE4 - Auto: remote contact starts, opening stops normally
// RULE5 - Faults and alarms reported to alarm module
// RULE6 - Power down after relays off 70 s
// RULE7 - Jumper fitted keeps controller powered always
// RULE8 - Setting selects fuel output run/stop polarity
// RULE9 - Six fault indicators, reverse power spare input
// RULE10 - Emergency stop cuts fuel, flashes indicator
// RULE11 - Transducer loss cuts fuel unless ignored
// RULE12 - Speed pickup loss cuts fuel, shows code
// RULE13 - Overcrank aborts start, flashes indicator
// RULE14 - After overcrank, start needs off/reset first
// RULE15 - Display cycles five parameters, selectable units
// RULE16 - Hold press toggles display freeze
// RULE17 - Lamp test lights all, ends after 10 s
// RULE18 - Overspeed cuts fuel, flashes indicator
// RULE19 - Verify switch lowers overspeed threshold to 75%
// RULE20 - Low oil pressure cuts fuel, flashes indicator
// RULE21 - Two oil setpoints split at oil step speed
// RULE22 - High coolant temperature cuts fuel, flashes
// RULE23 - Off/reset clears faults, stops engine immediately
// RULE24 - Starter released at crank termination speed
// RULE25 - Shutdown faults latch until off/reset
`ifndef ESSP_REGS_VH
`define ESSP_REGS_VH

// ********************************
// Register byte offsets
// ********************************
`define ESSP_CTRL_OFF 12'h000
`define ESSP_CRANK_OFF 12'h004
`define ESSP_REST_OFF 12'h008
`define ESSP_CYCLES_OFF 12'h00C
`define ESSP_COOL_OFF 12'h010
`define ESSP_CTS_OFF 12'h014
`define ESSP_OVSPD_OFF 12'h018
`define ESSP_OSTEP_OFF 12'h01C
`define ESSP_OILLO_OFF 12'h020
`define ESSP_OILHI_OFF 12'h024
`define ESSP_TEMP_OFF 12'h028
`define ESSP_STATUS_OFF 12'h02C
`define ESSP_FAULT_OFF 12'h030
`define ESSP_DISP_OFF 12'h034

// ********************************
// Control fields
// ********************************
`define ESSP_CTRL_ETS_BIT 0
`define ESSP_CTRL_IGN_XDCR_BIT 1
`define ESSP_CTRL_METRIC_BIT 2
`define ESSP_CTRL_RP_SPARE_BIT 3

// ********************************
// Reset values
// ********************************
`define ESSP_CTRL_RST 4'h0
`define ESSP_CRANK_RST 16'h000A
`define ESSP_REST_RST 16'h000A
`define ESSP_CYCLES_RST 4'h3
`define ESSP_COOL_RST 16'h012C
`define ESSP_CTS_RST 16'h0190
`define ESSP_OVSPD_RST 16'h07E9
`define ESSP_OSTEP_RST 16'h0514
`define ESSP_OILLO_RST 16'h0064
`define ESSP_OILHI_RST 16'h00C8
`define ESSP_TEMP_RST 16'h0069

// ********************************
// Timing
// ********************************
`define ESSP_CLK_MHZ 250
`define ESSP_POWER_DOWN_S 70
`define ESSP_LAMP_TEST_S 10
`define ESSP_DISP_STEP_S 2
`define ESSP_FLASH_HALF_MS 250
`define ESSP_SPEED_LOSS_S 2

`endif

// >>> logic/essp_top.v
// Engine start/stop and protection sequencer with APB register file
// Assumes synchronous inputs, speed as rpm word, one-second time base from divider
`timescale 1ns/10ps
`include "essp_regs.vh"

module essp_top #(
	parameter SEC_CYCLES = `ESSP_CLK_MHZ * 1000000,
	parameter FLASH_CYCLES = `ESSP_CLK_MHZ * 1000 * `ESSP_FLASH_HALF_MS
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [1:0] mode_selector_switch,
	input wire remote_initiate,
	input wire estop_in,
	input wire spare_fault_in,
	input wire [15:0] engine_rpm,
	input wire speed_valid,
	input wire [15:0] oil_pressure,
	input wire [15:0] coolant_temp,
	input wire xdcr_valid,
	input wire [15:0] battery_mv,
	input wire overspeed_verify,
	input wire display_hold,
	input wire lamp_test,
	input wire power_jumper,
	output reg fuel_out,
	output reg starter_out,
	output reg governor_rated,
	output reg [5:0] fault_led,
	output reg [5:0] alarm_report,
	output reg [3:0] diag_code,
	output reg [2:0] disp_sel,
	output reg [15:0] disp_value,
	output reg disp_metric,
	output reg lamp_all_on,
	output reg power_release
);

// ********************************
// Constants
// ********************************
localparam MODE_OFF = 2'd0;
localparam MODE_AUTO = 2'd1;
localparam MODE_RUN = 2'd2;
localparam MODE_STOP = 2'd3;
localparam ST_IDLE = 3'd0;
localparam ST_CRANK = 3'd1;
localparam ST_REST = 3'd2;
localparam ST_RUN = 3'd3;
localparam ST_COOL = 3'd4;
localparam ST_STOPPED = 3'd5;
localparam F_OC = 0;
localparam F_OS = 1;
localparam F_LOP = 2;
localparam F_HCT = 3;
localparam F_ES = 4;
localparam F_RP = 5;

// ********************************
// Registers
// ********************************
reg [3:0] ctrl_reg;
reg [15:0] crank_reg;
reg [15:0] rest_reg;
reg [15:0] cool_reg;
reg [15:0] cts_reg;
reg [15:0] ovspd_reg;
reg [15:0] ostep_reg;
reg [15:0] oillo_reg;
reg [15:0] oilhi_reg;
reg [15:0] temp_reg;
reg [3:0] cycles_reg;
reg [2:0] state_reg;
reg [15:0] tmr_reg;
reg [3:0] cyc_cnt_reg;
reg [5:0] fault_reg;
reg xdcr_fault_reg;
reg spd_fault_reg;
reg [31:0] div_reg;
reg sec_tick;
reg [31:0] fdiv_reg;
reg flash_reg;
reg [6:0] pd_cnt_reg;
reg [3:0] lt_cnt_reg;
reg lt_active_reg;
reg lamp_prev_reg;
reg hold_prev_reg;
reg hold_reg;
reg [1:0] dstep_reg;
reg [1:0] sloss_reg;

// ********************************
// Decoded conditions
// ********************************

wire apb_wr = psel & penable & pwrite & pready;
wire mode_clear = (mode_selector_switch == MODE_OFF);
wire shutdown_fault = (|fault_reg) | xdcr_fault_reg | spd_fault_reg;
wire run_req = (mode_selector_switch == MODE_RUN) | ((mode_selector_switch == MODE_AUTO) & remote_initiate); // RULE4
// Three times the overspeed setpoint; bits 17:2 give three quarters
wire [17:0] os_scaled = {2'b00, ovspd_reg} * 18'd3;
wire [15:0] os_limit = overspeed_verify ? os_scaled[17:2] : ovspd_reg; // RULE19
wire [15:0] oil_limit = (engine_rpm < ostep_reg) ? oillo_reg : oilhi_reg; // RULE21
wire engine_on = (state_reg == ST_RUN) | (state_reg == ST_COOL);
wire fuel_on = (state_reg == ST_CRANK) | engine_on;
wire spare_evt = ctrl_reg[`ESSP_CTRL_RP_SPARE_BIT] & spare_fault_in; // RULE9

// ********************************
// Time base and flash
// ********************************
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		div_reg <= 32'h00000000;
		sec_tick <= 1'b0;
		fdiv_reg <= 32'h00000000;
		flash_reg <= 1'b0;
	end else begin
		sec_tick <= (div_reg == SEC_CYCLES - 1);
		div_reg <= (div_reg == SEC_CYCLES - 1) ? 32'h00000000 : div_reg + 32'h00000001;
		// Flash phase shared by all fault indicators
		if (fdiv_reg == FLASH_CYCLES - 1) begin
			fdiv_reg <= 32'h00000000;
			flash_reg <= ~flash_reg;
		end else begin
			fdiv_reg <= fdiv_reg + 32'h00000001;
		end
	end
end

// ********************************
// APB slave
// ********************************
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h00000000;
		ctrl_reg <= `ESSP_CTRL_RST;
		crank_reg <= `ESSP_CRANK_RST;
		rest_reg <= `ESSP_REST_RST;
		cycles_reg <= `ESSP_CYCLES_RST;
		cool_reg <= `ESSP_COOL_RST;
		cts_reg <= `ESSP_CTS_RST;
		ovspd_reg <= `ESSP_OVSPD_RST;
		ostep_reg <= `ESSP_OSTEP_RST;
		oillo_reg <= `ESSP_OILLO_RST;
		oilhi_reg <= `ESSP_OILHI_RST;
		temp_reg <= `ESSP_TEMP_RST;
	end else begin
		pready <= psel & ~pready;
		pslverr <= 1'b0;
		// Read data taken in setup, shown with pready
		if (psel & ~pready) begin
			prdata <= 32'h00000000;
			if (paddr == `ESSP_CTRL_OFF) prdata <= {28'h0000000, ctrl_reg};
			else if (paddr == `ESSP_CRANK_OFF) prdata <= {16'h0000, crank_reg};
			else if (paddr == `ESSP_REST_OFF) prdata <= {16'h0000, rest_reg};
			else if (paddr == `ESSP_CYCLES_OFF) prdata <= {28'h0000000, cycles_reg};
			else if (paddr == `ESSP_COOL_OFF) prdata <= {16'h0000, cool_reg};
			else if (paddr == `ESSP_CTS_OFF) prdata <= {16'h0000, cts_reg};
			else if (paddr == `ESSP_OVSPD_OFF) prdata <= {16'h0000, ovspd_reg};
			else if (paddr == `ESSP_OSTEP_OFF) prdata <= {16'h0000, ostep_reg};
			else if (paddr == `ESSP_OILLO_OFF) prdata <= {16'h0000, oillo_reg};
			else if (paddr == `ESSP_OILHI_OFF) prdata <= {16'h0000, oilhi_reg};
			else if (paddr == `ESSP_TEMP_OFF) prdata <= {16'h0000, temp_reg};
			else if (paddr == `ESSP_STATUS_OFF) prdata <= {16'h0000, 3'b000, state_reg, 6'h00, tmr_reg[3:0]};
			else if (paddr == `ESSP_FAULT_OFF) prdata <= {16'h0000, 4'h0, diag_code, 2'b00, fault_reg};
			else if (paddr == `ESSP_DISP_OFF) prdata <= {13'h0000, disp_sel, disp_value};
			else pslverr <= 1'b1;
		end
		if (apb_wr) begin
			if (paddr == `ESSP_CTRL_OFF) ctrl_reg <= pwdata[3:0]; // RULE8
			else if (paddr == `ESSP_CRANK_OFF) crank_reg <= pwdata[15:0]; // RULE1
			else if (paddr == `ESSP_REST_OFF) rest_reg <= pwdata[15:0];
			else if (paddr == `ESSP_CYCLES_OFF) cycles_reg <= pwdata[3:0];
			else if (paddr == `ESSP_COOL_OFF) cool_reg <= pwdata[15:0];
			else if (paddr == `ESSP_CTS_OFF) cts_reg <= pwdata[15:0];
			else if (paddr == `ESSP_OVSPD_OFF) ovspd_reg <= pwdata[15:0];
			else if (paddr == `ESSP_OSTEP_OFF) ostep_reg <= pwdata[15:0];
			else if (paddr == `ESSP_OILLO_OFF) oillo_reg <= pwdata[15:0];
			else if (paddr == `ESSP_OILHI_OFF) oilhi_reg <= pwdata[15:0];
			else if (paddr == `ESSP_TEMP_OFF) temp_reg <= pwdata[15:0];
		end
	end
end

// ********************************
// Fault latches
// ********************************
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		fault_reg <= 6'h00;
		xdcr_fault_reg <= 1'b0;
		spd_fault_reg <= 1'b0;
		sloss_reg <= 2'b00;
	// Off/reset clear wins over any set
	end else if (mode_clear) begin
		fault_reg <= 6'h00; // RULE23 RULE25
		xdcr_fault_reg <= 1'b0;
		spd_fault_reg <= 1'b0;
		sloss_reg <= 2'b00;
	end else begin
		if (estop_in) fault_reg[F_ES] <= 1'b1; // RULE10
		if (spare_evt) fault_reg[F_RP] <= 1'b1;
		if (state_reg == ST_REST && cyc_cnt_reg >= cycles_reg) fault_reg[F_OC] <= 1'b1; // RULE13
		if (engine_on && engine_rpm > os_limit) fault_reg[F_OS] <= 1'b1; // RULE18
		if (state_reg == ST_RUN && governor_rated && xdcr_valid && oil_pressure < oil_limit)
			fault_reg[F_LOP] <= 1'b1; // RULE20
		if (engine_on && xdcr_valid && coolant_temp > temp_reg) fault_reg[F_HCT] <= 1'b1; // RULE22
		if (fuel_on && !xdcr_valid && !ctrl_reg[`ESSP_CTRL_IGN_XDCR_BIT]) xdcr_fault_reg <= 1'b1; // RULE11
		if (engine_on && !speed_valid && sec_tick) begin
			if (sloss_reg == `ESSP_SPEED_LOSS_S - 1) spd_fault_reg <= 1'b1; // RULE12
			else sloss_reg <= sloss_reg + 2'b01;
		end else if (speed_valid) begin
			sloss_reg <= 2'b00;
		end
	end
end

// ********************************
// Start/stop sequencer
// ********************************
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		state_reg <= ST_IDLE;
		tmr_reg <= 16'h0000;
		cyc_cnt_reg <= 4'h0;
	end else if (mode_clear || shutdown_fault) begin
		// Any latched fault holds idle, so starts are refused
		state_reg <= ST_IDLE; // RULE14 RULE23 RULE25
		tmr_reg <= 16'h0000;
		cyc_cnt_reg <= 4'h0;
	end else begin
		case (state_reg)
			ST_IDLE: begin
				if (run_req) begin
					state_reg <= ST_CRANK;
					tmr_reg <= 16'h0000;
					cyc_cnt_reg <= 4'h1;
				end
			end
			ST_CRANK: begin
				if (engine_rpm >= cts_reg) begin
					state_reg <= ST_RUN; // RULE24
				end else if (!run_req) begin
					state_reg <= ST_IDLE;
				end else if (sec_tick) begin
					if (tmr_reg >= crank_reg - 16'h0001) begin
						state_reg <= ST_REST; // RULE1
						tmr_reg <= 16'h0000;
					end else begin
						tmr_reg <= tmr_reg + 16'h0001;
					end
				end
			end
			ST_REST: begin
				if (!run_req) begin
					state_reg <= ST_IDLE;
				end else if (sec_tick) begin
					if (tmr_reg >= rest_reg - 16'h0001) begin
						state_reg <= ST_CRANK;
						tmr_reg <= 16'h0000;
						cyc_cnt_reg <= cyc_cnt_reg + 4'h1;
					end else begin
						tmr_reg <= tmr_reg + 16'h0001;
					end
				end
			end
			ST_RUN: begin
				if (!run_req) begin
					state_reg <= ST_COOL; // RULE3 RULE4
					tmr_reg <= 16'h0000;
				end
			end
			ST_COOL: begin
				if (run_req) begin
					state_reg <= ST_RUN;
				end else if (tmr_reg >= cool_reg) begin
					state_reg <= ST_STOPPED; // RULE3
				end else if (sec_tick) begin
					tmr_reg <= tmr_reg + 16'h0001;
				end
			end
			ST_STOPPED: begin
				if (!run_req) state_reg <= ST_IDLE;
			end
			default: state_reg <= ST_IDLE;
		endcase
	end
end

// ********************************
// Power down, lamp test, display
// ********************************
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pd_cnt_reg <= 7'h00;
		lt_cnt_reg <= 4'h0;
		lt_active_reg <= 1'b0;
		lamp_prev_reg <= 1'b0;
		hold_prev_reg <= 1'b0;
		hold_reg <= 1'b0;
		dstep_reg <= 2'b00;
		disp_sel <= 3'd0;
	end else begin
		if (fuel_out ^ ctrl_reg[`ESSP_CTRL_ETS_BIT] || starter_out) pd_cnt_reg <= 7'h00;
		else if (sec_tick && pd_cnt_reg != `ESSP_POWER_DOWN_S) pd_cnt_reg <= pd_cnt_reg + 7'h01; // RULE6
		lamp_prev_reg <= lamp_test;
		if (lamp_test && !lamp_prev_reg) begin
			lt_active_reg <= 1'b1;
			lt_cnt_reg <= 4'h0;
		end else if (!lamp_test) begin
			lt_active_reg <= 1'b0;
		end else if (sec_tick && lt_active_reg) begin
			if (lt_cnt_reg == `ESSP_LAMP_TEST_S - 1) lt_active_reg <= 1'b0; // RULE17
			else lt_cnt_reg <= lt_cnt_reg + 4'h1;
		end
		hold_prev_reg <= display_hold;
		if (display_hold && !hold_prev_reg) hold_reg <= ~hold_reg; // RULE16
		if (sec_tick && !hold_reg) begin
			if (dstep_reg == `ESSP_DISP_STEP_S - 1) begin
				dstep_reg <= 2'b00;
				disp_sel <= (disp_sel == 3'd4) ? 3'd0 : disp_sel + 3'd1; // RULE15
			end else begin
				dstep_reg <= dstep_reg + 2'b01;
			end
		end
	end
end

// ********************************
// Registered outputs
// ********************************
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		fuel_out <= 1'b0;
		starter_out <= 1'b0;
		governor_rated <= 1'b0;
		fault_led <= 6'h00;
		alarm_report <= 6'h00;
		diag_code <= 4'h0;
		disp_value <= 16'h0000;
		disp_metric <= 1'b0;
		lamp_all_on <= 1'b0;
		power_release <= 1'b0;
	end else begin
		fuel_out <= fuel_on ^ ctrl_reg[`ESSP_CTRL_ETS_BIT]; // RULE8
		starter_out <= (state_reg == ST_CRANK) && (engine_rpm < cts_reg); // RULE24
		governor_rated <= engine_on && xdcr_valid && (oil_pressure > oillo_reg); // RULE2
		fault_led <= lt_active_reg ? 6'h3F : (fault_reg & {6{flash_reg}}); // RULE9 RULE17
		alarm_report <= fault_reg; // RULE5
		diag_code <= spd_fault_reg ? 4'h2 : (xdcr_fault_reg ? 4'h1 : 4'h0); // RULE11 RULE12
		disp_metric <= ctrl_reg[`ESSP_CTRL_METRIC_BIT];
		lamp_all_on <= lt_active_reg;
		power_release <= mode_clear && !power_jumper && (pd_cnt_reg == `ESSP_POWER_DOWN_S); // RULE6 RULE7
		if (lt_active_reg) disp_value <= 16'hFFFF;
		else if (disp_sel == 3'd0) disp_value <= 16'h0000;
		else if (disp_sel == 3'd1) disp_value <= engine_rpm;
		else if (disp_sel == 3'd2) disp_value <= battery_mv;
		else if (disp_sel == 3'd3) disp_value <= oil_pressure;
		else disp_value <= coolant_temp;
	end
end

endmodule // essp_top

// >>> bench/essp_monitor.sv
// Concurrent checks on the engine sequencer ports
// Assumes binding to essp_top, with its one-second time base handed on
`timescale 1ns/10ps
module essp_monitor #(
	parameter SEC_CYCLES = 20
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire [1:0] mode_selector_switch,
	input wire estop_in,
	input wire [15:0] engine_rpm,
	input wire speed_valid,
	input wire overspeed_verify,
	input wire power_jumper,
	input wire starter_out,
	input wire governor_rated,
	input wire [5:0] alarm_report,
	input wire [3:0] diag_code,
	input wire lamp_all_on,
	input wire power_release
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	reg [31:0] loss_reg, lamp_reg, quiet_reg;
	wire live = mode_selector_switch != 2'h0;
	// ****************
	// Duration counters
	// ****************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loss_reg <= 32'h0;
			lamp_reg <= 32'h0;
			quiet_reg <= 32'h0;
		end else begin
			loss_reg <= (!speed_valid && governor_rated) ? loss_reg + 32'h1 : 32'h0;
			lamp_reg <= lamp_all_on ? lamp_reg + 32'h1 : 32'h0;
			quiet_reg <= (starter_out || governor_rated) ? 32'h0 : quiet_reg + 32'h1;
		end
	end
	sequence apb_setup;
		psel && !penable;
	endsequence
	sequence fault_held;
		alarm_report != 6'h00 [*2];
	endsequence
	// ****************
	// Assertions
	// ****************
	apb_ready_a: assert property (apb_setup |=> pready)
		else $error("no ready after setup");
	estop_latch_a: assert property ((estop_in && live) [*3] |-> alarm_report[4])
		else $error("estop not latched");
	overspeed_trip_a: assert property ((speed_valid && live && engine_rpm > 16'h07E9) [*3] |-> alarm_report[1])
		else $error("overspeed not latched");
	verify_trip_a: assert property ((overspeed_verify && speed_valid && live && engine_rpm >= 16'h0600) [*3]
		|-> alarm_report[1]) else $error("reduced overspeed not latched");
	fault_stop_a: assert property (fault_held |-> !starter_out && !governor_rated)
		else $error("engine driven with fault latched");
	offreset_clear_a: assert property (!live [*3] |-> alarm_report == 6'h00 && diag_code == 4'h0 && !starter_out)
		else $error("off/reset left faults or starter");
	crank_end_a: assert property ((speed_valid && engine_rpm >= 16'h0190) [*3] |-> !starter_out)
		else $error("starter held above termination speed");
	lamp_limit_a: assert property (lamp_reg <= 11 * SEC_CYCLES + 4)
		else $error("lamp test too long");
	speed_loss_a: assert property (loss_reg < 3 * SEC_CYCLES + 4)
		else $error("speed loss not tripped");
	jumper_hold_a: assert property (power_jumper [*2] |-> !power_release)
		else $error("power released with jumper");
	power_down_a: assert property (power_release |-> quiet_reg >= 69 * SEC_CYCLES)
		else $error("power released early");
endmodule // essp_monitor

bind essp_top essp_monitor #(.SEC_CYCLES(SEC_CYCLES)) mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .mode_selector_switch(mode_selector_switch), .estop_in(estop_in),
	.engine_rpm(engine_rpm), .speed_valid(speed_valid), .overspeed_verify(overspeed_verify),
	.power_jumper(power_jumper), .starter_out(starter_out), .governor_rated(governor_rated),
	.alarm_report(alarm_report), .diag_code(diag_code), .lamp_all_on(lamp_all_on), .power_release(power_release));

// >>> bench/essp_engine_model.sv
// Behavioural engine: speed and oil pressure from fuel and starter
// Assumes bench knobs for faults; ets gives the fuel output polarity
`timescale 1ns/10ps
module essp_engine_model (
	input wire pclk,
	input wire fuel_out,
	input wire starter_out,
	input wire energize_to_stop_fuel,
	input wire no_fire,
	input wire overrev,
	input wire oil_low,
	output wire [15:0] engine_rpm,
	output wire [15:0] oil_pressure
);
	reg [15:0] spd_reg = 16'h0000;
	wire fuel_on = fuel_out ^ energize_to_stop_fuel;
	// Fires while cranked with fuel, coasts down without
	always @(posedge pclk) begin
		if (fuel_on && (starter_out && !no_fire || spd_reg >= 16'h0190) && spd_reg < 16'h0708)
			spd_reg <= spd_reg + 16'h0064;
		else if (!fuel_on && spd_reg != 16'h0000)
			spd_reg <= spd_reg - 16'h0064;
	end
	assign engine_rpm = overrev ? spd_reg + 16'h0190 : spd_reg;
	assign oil_pressure = (oil_low || spd_reg < 16'h0190) ? 16'h0000 : 16'h012C;
endmodule // essp_engine_model

// >>> bench/engine_start_stop_protection_tb.sv
// Self-checking bench for the engine sequencer
// Assumes a one-second time base of 20 cycles and the engine model
`timescale 1ns/10ps
`include "essp_regs.vh"
module engine_start_stop_protection_tb;
	localparam S = 20;
	localparam [79:0] EXP = {10'h080, 10'h002, 10'h040, 10'h020, 10'h008, 10'h004, 10'h002, 10'h010};
	reg pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e, p;
	reg remote = 1'h0, estop = 1'h0, spare = 1'h0, spd_ok = 1'h1, xd_ok = 1'h1, verify = 1'h0, hold = 1'h0;
	reg lamp = 1'h0, jumper = 1'h1, energize_to_stop_fuel = 1'h0, no_fire = 1'h0, overrev = 1'h0, oil_low = 1'h0;
	reg [1:0] mode = 2'h0;
	reg [11:0] paddr = 12'h0;
	reg [15:0] temp = 16'h0050;
	reg [31:0] pwdata = 32'h0, q;
	wire [31:0] prdata;
	wire pready, pslverr, fuel, starter, gov, metric, lamp_on, prel;
	wire [5:0] led, alarm;
	wire [3:0] diag;
	wire [2:0] sel;
	wire [15:0] rpm, oil, dval;
	integer miscompares = 0, comparisons = 0, cyc = 0, n, k, m;
	essp_top #(.SEC_CYCLES(S), .FLASH_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mode_selector_switch(mode), .remote_initiate(remote), .estop_in(estop),
		.spare_fault_in(spare), .engine_rpm(rpm), .speed_valid(spd_ok), .oil_pressure(oil), .coolant_temp(temp),
		.xdcr_valid(xd_ok), .battery_mv(16'h3000), .overspeed_verify(verify), .display_hold(hold),
		.lamp_test(lamp), .power_jumper(jumper), .fuel_out(fuel), .starter_out(starter), .governor_rated(gov),
		.fault_led(led), .alarm_report(alarm), .diag_code(diag), .disp_sel(sel), .disp_value(dval),
		.disp_metric(metric), .lamp_all_on(lamp_on), .power_release(prel));
	essp_engine_model eng (.pclk(pclk), .fuel_out(fuel), .starter_out(starter), .energize_to_stop_fuel(energize_to_stop_fuel), .no_fire(no_fire),
		.overrev(overrev), .oil_low(oil_low), .engine_rpm(rpm), .oil_pressure(oil));
	initial forever #2 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			complete_run;
		end
	end
	// ****************
	// Shared tasks
	// ****************
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, wr, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task run_up(input logic [1:0] md);
		@(posedge pclk);
		mode <= md;
		for (n = 0; gov !== 1'h1 && n < 20 * S; n++) @(posedge pclk);
		check(gov, 1'h1);
		check(starter, 1'h0);
		check(fuel ^ energize_to_stop_fuel, 1'h1);
	endtask
	task off;
		@(posedge pclk);
		mode <= 2'h0;
		repeat (3) @(posedge pclk);
		for (n = 0; rpm !== 16'h0000 && n < 50; n++) @(posedge pclk);
	endtask
	task complete_run;
		$display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ****************
	// Scenarios
	// ****************
	task t_regs;
		apb(1'h0, `ESSP_OVSPD_OFF, 32'h0);
		check(q, 32'h7E9);
		apb(1'h0, 12'h040, 32'h0);
		check(e, 1'h1);
		check(q, 32'h0);
		apb(1'h1, `ESSP_STATUS_OFF, 32'hF);
		check(e, 1'h0);
		apb(1'h1, `ESSP_CRANK_OFF, 32'h3);
		apb(1'h1, `ESSP_REST_OFF, 32'h2);
		apb(1'h1, `ESSP_CYCLES_OFF, 32'h2);
		apb(1'h1, `ESSP_COOL_OFF, 32'h4);
		apb(1'h0, `ESSP_CRANK_OFF, 32'h0);
		check(q, 32'h3);
		$display("registers done");
	endtask
	task t_auto;
		@(posedge pclk);
		remote <= 1'h1;
		run_up(2'h1);
		remote <= 1'h0;
		repeat (2 * S) @(posedge pclk);
		check(fuel, 1'h1);
		for (n = 0; fuel !== 1'h0 && n < 8 * S; n++) @(posedge pclk);
		check({fuel, n >= S}, 2'h1);
		off;
		$display("auto cooldown done");
	endtask
	task t_crank;
		@(posedge pclk);
		{no_fire, mode} <= 3'h6;
		{k, m, p} = 0;
		for (n = 0; alarm[0] !== 1'h1 && n < 30 * S; n++) begin
			@(posedge pclk);
			k += (starter && !p);
			p = starter;
		end
		check(k, 2);
		k = 0;
		repeat (8 * S) begin
			@(posedge pclk);
			k += starter;
			m += (led[0] != p);
			p = led[0];
		end
		check(k, 0);
		check(m > 2, 1);
		no_fire <= 1'h0;
		off;
		check(alarm, 6'h00);
		$display("overcrank done");
	endtask
	task t_faults;
		apb(1'h1, `ESSP_CTRL_OFF, 32'h8);
		for (k = 0; k < 8; k++) begin
			run_up(2'h2);
			case (k)
				0: estop <= 1'h1;
				1: verify <= 1'h1;
				2: oil_low <= 1'h1;
				3: temp <= 16'h0078;
				4: spare <= 1'h1;
				5: xd_ok <= 1'h0;
				6: overrev <= 1'h1;
				default: spd_ok <= 1'h0;
			endcase
			for (n = 0; {diag, alarm} === 10'h0 && n < 5 * S; n++) @(posedge pclk);
			repeat (3) @(posedge pclk);
			check(fuel, 1'h0);
			check({diag, alarm}, EXP[k * 10 +: 10]);
			{estop, verify, oil_low, spare, overrev, xd_ok, spd_ok, temp} <= {7'h3, 16'h0050};
			off;
			check({diag, alarm}, 10'h0);
		end
		$display("shutdown faults done");
	endtask
	task t_ctrl;
		apb(1'h1, `ESSP_CTRL_OFF, 32'h7);
		energize_to_stop_fuel <= 1'h1;
		repeat (3) @(posedge pclk);
		check({fuel, metric}, 2'h3);
		run_up(2'h2);
		xd_ok <= 1'h0;
		repeat (2 * S) @(posedge pclk);
		check({fuel, diag, alarm}, 11'h0);
		xd_ok <= 1'h1;
		mode <= 2'h3;
		repeat (S) @(posedge pclk);
		check(fuel, 1'h0);
		off;
		apb(1'h1, `ESSP_CTRL_OFF, 32'h0);
		energize_to_stop_fuel <= 1'h0;
		$display("control bits done");
	endtask
	task t_panel;
		@(posedge pclk);
		lamp <= 1'h1;
		repeat (3) @(posedge pclk);
		check({lamp_on, led, dval}, 23'h7FFFFF);
		repeat (12 * S) @(posedge pclk);
		check(lamp_on, 1'h0);
		{lamp, hold} <= 2'h1;
		@(posedge pclk);
		hold <= 1'h0;
		@(posedge pclk);
		k = sel;
		repeat (6 * S) @(posedge pclk);
		check(sel, k);
		hold <= 1'h1;
		@(posedge pclk);
		hold <= 1'h0;
		repeat (6 * S) @(posedge pclk);
		check(sel != k, 1'h1);
		for (n = 0; sel !== 3'h2 && n < 12 * S; n++) @(posedge pclk);
		repeat (2) @(posedge pclk);
		check(dval, 16'h3000);
		$display("panel done");
	endtask
	task t_power;
		jumper <= 1'h0;
		for (n = 0; prel !== 1'h1 && n < 75 * S; n++) @(posedge pclk);
		check(prel, 1'h1);
		jumper <= 1'h1;
		repeat (3) @(posedge pclk);
		check(prel, 1'h0);
		$display("power down done");
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		t_regs;
		t_auto;
		t_crank;
		t_faults;
		t_ctrl;
		t_panel;
		t_power;
		complete_run;
	end
endmodule // engine_start_stop_protection_tb
